/* shared/ursf_pkg.sv */
package ursf_pkg;

    // ************************************************************
    // Register map (byte addresses; printed offsets not all /4)
    // ************************************************************
    localparam logic [11:0] RX_STATUS_IDX  = 12'hF41;
    localparam logic [11:0] RX_DATA_IDX    = 12'hF40;
    localparam logic [11:0] RX_CTRL_IDX    = 12'hF42;
    localparam logic [13:0] RX_STATUS_ADDR = {RX_STATUS_IDX, 2'b00};
    localparam logic [13:0] RX_DATA_ADDR   = {RX_DATA_IDX, 2'b00};
    localparam logic [13:0] RX_CTRL_ADDR   = {RX_CTRL_IDX, 2'b00};

    // ************************************************************
    // Status field positions
    // ************************************************************
    localparam int BIT_RX_READY  = 7;
    localparam int BIT_PARITY    = 6;
    localparam int BIT_OVERRUN   = 5;
    localparam int BIT_STOP      = 4;
    localparam int BIT_BREAK     = 3;
    localparam int BIT_TX_HOLD   = 2;
    localparam int BIT_TX_ALL    = 1;
    localparam int BIT_CTS       = 0;

    // Control fields: [0] parity enable, [1] odd parity, [2] two stop bits
    localparam int CTL_PAR_EN    = 0;
    localparam int CTL_PAR_ODD   = 1;
    localparam int CTL_STOP2     = 2;
    localparam logic [7:0] CTRL_RESET   = 8'h00;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ        = 10_000_000;
    localparam int BAUD_DEFAULT  = 9600;
    localparam int DEPTH_DEFAULT = 2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        RX_IDLE   = 3'b000,
        RX_START  = 3'b001,
        RX_DATA   = 3'b011,
        RX_PARITY = 3'b010,
        RX_STOP   = 3'b110
    } ursf_rx_state_t;

    typedef struct packed {
        logic       ok;
        logic [7:0] data;
        logic       par_err;
        logic       stop_err;
        logic       brk;
    } ursf_frame_t;

endpackage : ursf_pkg

/* hdl/ursf_sync.sv */
`timescale 1ns/1ps
module ursf_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } ursf_sync_t;

    ursf_sync_t st_r;
    ursf_sync_t st_nxt;

    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;

endmodule : ursf_sync

/* hdl/ursf_top.sv */
`timescale 1ns/1ps
module ursf_top #(
    parameter int BAUD = ursf_pkg::BAUD_DEFAULT
) (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Line side
    input  wire logic        rxd,
    input  wire logic        cts_n,
    // Transmit side status, from the transmitter
    input  wire logic        tx_hold_empty_in,
    input  wire logic        tx_all_empty_in
);

    // ************************************************************
    // Constants
    // ************************************************************
    localparam int          DIV_I  = ursf_pkg::CLK_HZ / BAUD;
    localparam logic [15:0] DIV    = 16'(DIV_I);
    localparam logic [15:0] HALF   = 16'(DIV_I / 2);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        ursf_pkg::ursf_rx_state_t fsm;
        logic [15:0] cnt;
        logic [2:0]  bitn;
        logic        stopn;
        logic [7:0]  shift;
        logic        par_acc;
        logic        zero_acc;
        logic [7:0]  data;
        logic [7:0]  ctrl;
        logic        rx_byte_ready;
        logic        parity_fault_flag;
        logic        overrun_flag;
        logic        stop_bit_fault_flag;
        logic        line_break_seen;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
    } ursf_state_t;

    ursf_state_t st_r;
    ursf_state_t st_nxt;

    logic [3:0] pin_s;
    logic       rx_s;
    logic       cts_s;
    logic       txh_s;
    logic       txa_s;

    ursf_sync #(
        .WIDTH (4)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({rxd, cts_n, tx_hold_empty_in, tx_all_empty_in}),
        .q       (pin_s)
    );

    assign rx_s  = pin_s[3];
    assign cts_s = pin_s[2];
    assign txh_s = pin_s[1];
    assign txa_s = pin_s[0];

    // ************************************************************
    // Next state
    // ************************************************************
    logic        setup;
    logic        rd_data;
    logic        tick;
    logic        frame_done;
    ursf_pkg::ursf_frame_t fr;
    logic [7:0]  status;

    always_comb begin
        st_nxt     = st_r;
        setup      = psel && !penable;
        rd_data    = setup && !pwrite && (paddr == ursf_pkg::RX_DATA_ADDR);
        tick       = (st_r.cnt == 16'h0000);
        frame_done = 1'b0;
        fr         = '0;
        status     = '0;
        status[ursf_pkg::BIT_RX_READY] = st_r.rx_byte_ready;
        status[ursf_pkg::BIT_PARITY]   = st_r.parity_fault_flag;
        status[ursf_pkg::BIT_OVERRUN]  = st_r.overrun_flag;
        status[ursf_pkg::BIT_STOP]     = st_r.stop_bit_fault_flag;
        status[ursf_pkg::BIT_BREAK]    = st_r.line_break_seen;
        status[ursf_pkg::BIT_TX_HOLD]  = txh_s;
        status[ursf_pkg::BIT_TX_ALL]   = txa_s;
        status[ursf_pkg::BIT_CTS]      = cts_s;

        // Receiver
        if (!tick) begin
            st_nxt.cnt = st_r.cnt - 16'h0001;
        end
        case (st_r.fsm)
            ursf_pkg::RX_IDLE: begin
                if (!rx_s) begin
                    st_nxt.fsm = ursf_pkg::RX_START;
                    st_nxt.cnt = HALF;
                end
            end
            ursf_pkg::RX_START: begin
                if (tick) begin
                    if (rx_s) begin
                        st_nxt.fsm = ursf_pkg::RX_IDLE;
                    end else begin
                        st_nxt.fsm      = ursf_pkg::RX_DATA;
                        st_nxt.cnt      = DIV - 16'h0001;
                        st_nxt.bitn     = 3'h0;
                        st_nxt.par_acc  = st_r.ctrl[ursf_pkg::CTL_PAR_ODD];
                        st_nxt.zero_acc = 1'b1;
                    end
                end
            end
            ursf_pkg::RX_DATA: begin
                if (tick) begin
                    st_nxt.shift    = {rx_s, st_r.shift[7:1]};
                    st_nxt.par_acc  = st_r.par_acc ^ rx_s;
                    st_nxt.zero_acc = st_r.zero_acc & !rx_s;
                    st_nxt.cnt      = DIV - 16'h0001;
                    st_nxt.bitn     = st_r.bitn + 3'h1;
                    st_nxt.stopn    = st_r.ctrl[ursf_pkg::CTL_STOP2];
                    if (st_r.bitn == 3'h7) begin
                        st_nxt.fsm = st_r.ctrl[ursf_pkg::CTL_PAR_EN] ? ursf_pkg::RX_PARITY
                                                                     : ursf_pkg::RX_STOP;
                    end
                end
            end
            ursf_pkg::RX_PARITY: begin
                if (tick) begin
                    st_nxt.par_acc  = st_r.par_acc ^ rx_s;
                    st_nxt.zero_acc = st_r.zero_acc & !rx_s;
                    st_nxt.cnt      = DIV - 16'h0001;
                    st_nxt.fsm      = ursf_pkg::RX_STOP;
                end
            end
            ursf_pkg::RX_STOP: begin
                if (tick) begin
                    st_nxt.zero_acc = st_r.zero_acc & !rx_s;
                    st_nxt.cnt      = DIV - 16'h0001;
                    if (!rx_s || !st_r.stopn) begin
                        frame_done  = 1'b1;
                        st_nxt.fsm  = ursf_pkg::RX_IDLE;
                    end else begin
                        st_nxt.stopn = 1'b0;
                    end
                end
            end
            default: begin
                st_nxt.fsm = ursf_pkg::RX_IDLE;
            end
        endcase

        fr.ok       = frame_done;
        fr.data     = st_r.shift;
        fr.par_err  = st_r.ctrl[ursf_pkg::CTL_PAR_EN] && st_r.par_acc;
        fr.stop_err = !rx_s;
        fr.brk      = st_r.zero_acc && !rx_s;

        // Flags: a data read clears (overrun only when no byte is ready), a completing frame sets and wins
        if (rd_data) begin
            st_nxt.rx_byte_ready       = 1'b0;
            st_nxt.parity_fault_flag   = 1'b0;
            st_nxt.stop_bit_fault_flag = 1'b0;
            st_nxt.line_break_seen     = 1'b0;
            if (!st_r.rx_byte_ready) begin
                st_nxt.overrun_flag = 1'b0;
            end
        end
        if (fr.ok) begin
            if (st_r.rx_byte_ready && !rd_data) begin
                st_nxt.overrun_flag = 1'b1;
            end
            st_nxt.data          = fr.data;
            st_nxt.rx_byte_ready = 1'b1;
            if (fr.par_err) begin
                st_nxt.parity_fault_flag = 1'b1;
            end
            if (fr.stop_err) begin
                st_nxt.stop_bit_fault_flag = 1'b1;
            end
            if (fr.brk) begin
                st_nxt.line_break_seen = 1'b1;
            end
        end

        // APB: zero-wait answer, registered
        st_nxt.ready  = setup;
        st_nxt.slverr = 1'b0;
        st_nxt.rdata  = '0;
        if (setup) begin
            case (paddr)
                ursf_pkg::RX_STATUS_ADDR: begin
                    st_nxt.rdata  = {24'h000000, status};
                    st_nxt.slverr = pwrite;
                end
                ursf_pkg::RX_DATA_ADDR: begin
                    st_nxt.rdata  = {24'h000000, st_r.data};
                    st_nxt.slverr = pwrite;
                end
                ursf_pkg::RX_CTRL_ADDR: begin
                    st_nxt.rdata = {24'h000000, st_r.ctrl};
                    if (pwrite) begin
                        st_nxt.ctrl = pwdata[7:0];
                    end
                end
                default: begin
                    st_nxt.slverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r      <= '0;
            st_r.fsm  <= ursf_pkg::RX_IDLE;
            st_r.ctrl <= ursf_pkg::CTRL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata  = st_r.rdata;
    assign pready  = st_r.ready;
    assign pslverr = st_r.slverr;

endmodule : ursf_top

/* test/ursf_top_sva.sv */
`timescale 1ns/1ps
module ursf_top_sva (
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Line and transmitter status
    input wire logic        rxd,
    input wire logic        cts_n,
    input wire logic        tx_hold_empty_in,
    input wire logic        tx_all_empty_in
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic st_rd;
    assign st_rd = pready && !pwrite && !pslverr && paddr == ursf_pkg::RX_STATUS_ADDR;
    a_answer_next: assert property (psel && !penable |=> pready && penable)
        else $error("setup not answered");
    a_answer_cause: assert property (pready |-> $past(psel && !penable))
        else $error("stray ready");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_status_ro: assert property (pready && pwrite && paddr == ursf_pkg::RX_STATUS_ADDR |-> pslverr)
        else $error("status write accepted");
    a_parity_ready: assert property (
        st_rd && prdata[6] |-> prdata[7]) else $error("parity flag without byte");
    a_stop_ready: assert property (
        st_rd && prdata[4] |-> prdata[7]) else $error("stop flag without byte");
    a_break_stop: assert property (
        st_rd && prdata[3] |-> prdata[4] && prdata[7]) else $error("break without stop fault");
endmodule : ursf_top_sva

bind ursf_top ursf_top_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .cts_n(cts_n),
    .tx_hold_empty_in(tx_hold_empty_in), .tx_all_empty_in(tx_all_empty_in));

/* test/ursf_line_model.sv */
`timescale 1ns/1ps
module ursf_line_model #(
    parameter int BIT_CYC = 10
) (
    // Clock
    input wire logic pclk,
    // Serial line
    output logic     rxd
);
    initial rxd = 1'h1;
    task automatic send_bit(input logic v);
        rxd <= v;
        repeat (BIT_CYC) @(posedge pclk);
    endtask : send_bit
    // Start, data LSB first, optional parity, one stop bit, then an idle bit
    task automatic send(input logic [7:0] d, input logic pe, input logic p, input logic stp);
        send_bit(1'h0);
        for (int i = 0; i < 8; i++) send_bit(d[i]);
        if (pe) send_bit(p);
        send_bit(stp);
        send_bit(1'h1);
    endtask : send
endmodule : ursf_line_model

/* test/ursf_top_tb_top.sv */
`timescale 1ns/1ps
module ursf_top_tb_top;
    // ********************
    // Wiring
    // ********************
    localparam logic [13:0] ST = ursf_pkg::RX_STATUS_ADDR;
    localparam logic [13:0] DT = ursf_pkg::RX_DATA_ADDR;
    typedef struct packed {logic err; logic [31:0] mask; logic [31:0] data;} ursf_exp_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0]  low;
    logic [7:0]  b;
    ursf_exp_t   e;
    ursf_exp_t   exp_q[$];
    int          error_cnt = 0;
    int          checked = 0;
    int          cyc = 0;
    ursf_top #(.BAUD(1_000_000)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .cts_n(low[0]),
        .tx_hold_empty_in(low[2]), .tx_all_empty_in(low[1]));
    ursf_line_model #(.BIT_CYC(10)) i_line (.pclk(pclk), .rxd(rxd));
    // ********************
    // Tasks
    // ********************
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        checked++;
        if (seen !== expv) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic err);
        exp_q.push_back('{err, m, w ? 32'h0 : d});
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb
    task automatic stat(input logic [7:0] f);
        apb(1'h0, ST, {24'h0, f[7:3], low}, 32'hFF, 1'h0);
    endtask : stat
    task automatic frame(input logic [7:0] d, input logic pe, input logic p, input logic s,
                         input logic [7:0] f);
        i_line.send(d, pe, p, s);
        stat(f);
    endtask : frame
    // ********************
    // Clock, watchdog, result monitor
    // ********************
    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    always @(posedge pclk) begin
        if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1) begin
            if (exp_q.size() == 0) begin
                error_cnt++;
            end else begin
                e = exp_q.pop_front();
                check(prdata & e.mask, e.data);
                check({31'h0, pslverr}, {31'h0, e.err});
            end
        end
    end
    // ********************
    // Scenarios
    // ********************
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(32'h65be18f3));
        low = 3'($urandom);
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        repeat (3) @(posedge pclk);
        stat(8'h00);
        apb(1'h0, ursf_pkg::RX_CTRL_ADDR, 32'h0, 32'hFF, 1'h0);
        apb(1'h0, 14'h0010, 32'h0, 32'hFFFFFFFF, 1'h1);
        apb(1'h1, ST, 32'hFF, 32'h0, 1'h1);
        b = 8'($urandom) | 8'h01;
        frame(b, 1'h0, 1'h0, 1'h1, 8'h80);
        apb(1'h0, DT, {24'h0, b}, 32'hFF, 1'h0);
        stat(8'h00);
        frame(b, 1'h0, 1'h0, 1'h1, 8'h80);
        frame(~b, 1'h0, 1'h0, 1'h1, 8'hA0);
        apb(1'h0, DT, 32'h0, 32'h0, 1'h0);
        stat(8'h20);
        apb(1'h0, DT, 32'h0, 32'h0, 1'h0);
        stat(8'h00);
        frame(b, 1'h0, 1'h0, 1'h0, 8'h90);
        apb(1'h0, DT, 32'h0, 32'h0, 1'h0);
        stat(8'h00);
        frame(8'h00, 1'h0, 1'h0, 1'h0, 8'h98);
        apb(1'h0, DT, 32'h0, 32'h0, 1'h0);
        stat(8'h00);
        // Two stop bits, parity off: the model's parity slot is the first stop bit
        apb(1'h1, ursf_pkg::RX_CTRL_ADDR, 32'h4, 32'h0, 1'h0);
        apb(1'h0, ursf_pkg::RX_CTRL_ADDR, 32'h4, 32'hFF, 1'h0);
        frame(b, 1'h1, 1'h1, 1'h1, 8'h80);
        apb(1'h0, DT, {24'h0, b}, 32'hFF, 1'h0);
        frame(b, 1'h1, 1'h1, 1'h0, 8'h90);
        apb(1'h0, DT, 32'h0, 32'h0, 1'h0);
        stat(8'h00);
        for (int m = 0; m < 2; m++) begin
            apb(1'h1, ursf_pkg::RX_CTRL_ADDR, {30'h0, 1'(m), 1'h1}, 32'h0, 1'h0);
            frame(b, 1'h1, (^b) ^ 1'(m), 1'h1, 8'h80);
            apb(1'h0, DT, {24'h0, b}, 32'hFF, 1'h0);
            frame(b, 1'h1, ~((^b) ^ 1'(m)), 1'h1, 8'hC0);
            apb(1'h0, DT, 32'h0, 32'h0, 1'h0);
            stat(8'h00);
        end
        report_and_stop();
    end
endmodule : ursf_top_tb_top
